// ---- core/hash_compression_consts.vh ----
// Purpose: Shared constants of the hash compression core
// Assumes: Included by bare name from the design files
// Notes  : Definitions only, no logic
`ifndef HASH_COMPRESSION_CONSTS_VH
`define HASH_COMPRESSION_CONSTS_VH

// ============================================================
// Round counts per word width
// ============================================================
`define HCC_ROUNDS_NARROW 5'h0_E
`define HCC_ROUNDS_WIDE   5'h1_0

// ============================================================
// Rotation amounts of the mixing step
// ============================================================
`define HCC_ROT0_NARROW 16
`define HCC_ROT1_NARROW 12
`define HCC_ROT2_NARROW 8
`define HCC_ROT3_NARROW 7
`define HCC_ROT0_WIDE   32
`define HCC_ROT1_WIDE   24
`define HCC_ROT2_WIDE   16
`define HCC_ROT3_WIDE   8

// ============================================================
// Generator of the sixteen round constants (arbitrary values)
// ============================================================
`define HCC_CONST_SEED 64'h9E37_79B9_7F4A_7C15
`define HCC_CONST_STEP 64'h6A09_E667_BB67_AE85

`endif

// ---- core/hash_g_mix.v ----
// Purpose: One mixing step on four state words
// Assumes: Purely combinational, used four lanes wide
// Notes  : Rotation amounts come in as parameters
`timescale 1ns/10ps
`default_nettype none

module hash_g_mix #(
   parameter WORD_W = 32,            // Word width
   parameter ROT0   = 16,            // First rotation
   parameter ROT1   = 12,            // Second rotation
   parameter ROT2   = 8,             // Third rotation
   parameter ROT3   = 7              // Fourth rotation
) (
   input  wire [WORD_W-1:0] a_i,     // Word a in
   input  wire [WORD_W-1:0] b_i,     // Word b in
   input  wire [WORD_W-1:0] c_i,     // Word c in
   input  wire [WORD_W-1:0] d_i,     // Word d in
   input  wire [WORD_W-1:0] m0_i,    // First message word
   input  wire [WORD_W-1:0] k0_i,    // Constant paired with m0
   input  wire [WORD_W-1:0] m1_i,    // Second message word
   input  wire [WORD_W-1:0] k1_i,    // Constant paired with m1
   output wire [WORD_W-1:0] a_o,     // Word a out
   output wire [WORD_W-1:0] b_o,     // Word b out
   output wire [WORD_W-1:0] c_o,     // Word c out
   output wire [WORD_W-1:0] d_o      // Word d out
);

   // ==========================================================
   // Rotate right helper
   // ==========================================================
   function [WORD_W-1:0] rotr;
      input [WORD_W-1:0] x;
      input integer      n;
      begin
         rotr = (x >> n) | (x << (WORD_W - n));
      end
   endfunction

   // ==========================================================
   // First half: add, xor, rotate
   // ==========================================================
   wire [WORD_W-1:0] a1 = a_i + b_i + (m0_i ^ k0_i);   // Mix in m0
   wire [WORD_W-1:0] d1 = rotr(d_i ^ a1, ROT0);        // Spread a
   wire [WORD_W-1:0] c1 = c_i + d1;                     // Carry d
   wire [WORD_W-1:0] b1 = rotr(b_i ^ c1, ROT1);        // Spread c

   // ==========================================================
   // Second half: same pattern with the swapped pair
   // ==========================================================
   wire [WORD_W-1:0] a2 = a1 + b1 + (m1_i ^ k1_i);     // Mix in m1
   wire [WORD_W-1:0] d2 = rotr(d1 ^ a2, ROT2);         // Spread a
   wire [WORD_W-1:0] c2 = c1 + d2;                      // Carry d
   wire [WORD_W-1:0] b2 = rotr(b1 ^ c2, ROT3);         // Spread c

   assign a_o = a2;
   assign b_o = b2;
   assign c_o = c2;
   assign d_o = d2;

endmodule // hash_g_mix

`default_nettype wire

// ---- core/hash_compression_core.v ----
// Purpose: Compression function of a 32/64-bit-word hash
// Assumes: Block, chain, salt and counter come from same-clock logic
// Notes  : Two cycles per round, column then diagonal step
`timescale 1ns/10ps
`default_nettype none
`include "hash_compression_consts.vh"

module hash_compression_core #(
   parameter WORD_W = 32             // 32 or 64 bit words
) (
   input  wire                 CLK_I,    // Clock, 40 MHz
   input  wire                 RST_N_I,  // Sync reset, active low
   input  wire                 START_I,  // Start one compression
   input  wire [16*WORD_W-1:0] BLOCK_I,  // Message block, word 0 low
   input  wire [8*WORD_W-1:0]  CHAIN_I,  // Incoming chain value
   input  wire [4*WORD_W-1:0]  SALT_I,   // Salt
   input  wire [2*WORD_W-1:0]  COUNT_I,  // Counter, low word low
   output wire                 BUSY_O,   // Compression in progress
   output reg                  DONE_O,   // One-cycle completion pulse
   output reg  [8*WORD_W-1:0]  CHAIN_O   // New chain value
);

   // ==========================================================
   // Variant selection
   // ==========================================================
   localparam WIDE = (WORD_W == 64);
   localparam [4:0] ROUNDS = WIDE ? `HCC_ROUNDS_WIDE
                                  : `HCC_ROUNDS_NARROW;
   localparam [3:0] LAST_ROUND = ROUNDS[3:0] - 4'h1;      // Final index
   localparam ROT0 = WIDE ? `HCC_ROT0_WIDE : `HCC_ROT0_NARROW;
   localparam ROT1 = WIDE ? `HCC_ROT1_WIDE : `HCC_ROT1_NARROW;
   localparam ROT2 = WIDE ? `HCC_ROT2_WIDE : `HCC_ROT2_NARROW;
   localparam ROT3 = WIDE ? `HCC_ROT3_WIDE : `HCC_ROT3_NARROW;

   // ==========================================================
   // One-hot states
   // ==========================================================
   localparam [3:0] ST_IDLE  = 4'h1;   // Waiting for start
   localparam [3:0] ST_LOAD  = 4'h2;   // Build initial state
   localparam [3:0] ST_ROUND = 4'h4;   // Run column/diagonal steps
   localparam [3:0] ST_FINAL = 4'h8;   // Fold state to chain value

   // ==========================================================
   // Round constant generator
   // ==========================================================
   function [WORD_W-1:0] const_word;
      input integer idx;
      reg   [63:0]  prod;
      begin
         prod = `HCC_CONST_SEED ^ (`HCC_CONST_STEP * idx);
         const_word = prod[WORD_W-1:0];
      end
   endfunction

   // ==========================================================
   // Registers
   // ==========================================================
   reg  [3:0]           state_reg;     // Current state
   reg  [3:0]           state_next;    // Next state
   reg  [3:0]           round_reg;     // Round index
   reg  [3:0]           round_next;    // Next round index
   reg                  diag_reg;      // 0 column step, 1 diagonal
   reg                  diag_next;     // Next step kind
   reg  [16*WORD_W-1:0] v_reg;         // Inner state
   reg  [16*WORD_W-1:0] v_next;        // Next inner state
   reg  [16*WORD_W-1:0] msg_reg;       // Latched message block
   reg  [8*WORD_W-1:0]  chain_reg;     // Latched chain value
   reg  [4*WORD_W-1:0]  salt_reg;      // Latched salt
   reg  [2*WORD_W-1:0]  count_reg;     // Latched counter
   reg  [8*WORD_W-1:0]  fold_w;        // Finalization result

   wire [16*WORD_W-1:0] const_flat;    // All sixteen constants
   wire [4*WORD_W-1:0]  ga_flat;       // Lane outputs a
   wire [4*WORD_W-1:0]  gb_flat;       // Lane outputs b
   wire [4*WORD_W-1:0]  gc_flat;       // Lane outputs c
   wire [4*WORD_W-1:0]  gd_flat;       // Lane outputs d
   wire [15:0]          ib_flat;       // Lane word index of b
   wire [15:0]          ic_flat;       // Lane word index of c
   wire [15:0]          id_flat;       // Lane word index of d
   wire [3:0]           mult_w;        // Odd multiplier per round

   assign BUSY_O = ~state_reg[0];
   assign mult_w = {round_reg[2:0], 1'b1};   // Odd: bijective mod 16

   // ==========================================================
   // Constant table
   // ==========================================================
   genvar gk;
   generate
      for (gk = 0; gk < 16; gk = gk + 1) begin : g_const
         assign const_flat[gk*WORD_W +: WORD_W] = const_word(gk);
      end
   endgenerate

   // ==========================================================
   // Four mixing lanes with permuted word selection
   // ==========================================================
   genvar gj;
   generate
      for (gj = 0; gj < 4; gj = gj + 1) begin : g_lane
         localparam [31:0] LANE = gj;                // Lane number, full width
         localparam [1:0]  JJ   = LANE[1:0];         // Column within a row
         wire [1:0] ob = JJ + {1'b0, diag_reg};      // Diagonal shift b
         wire [1:0] oc = JJ + {diag_reg, 1'b0};      // Diagonal shift c
         wire [1:0] od = JJ + {diag_reg, diag_reg};  // Diagonal shift d
         wire [3:0] ib = {2'b01, ob};
         wire [3:0] ic = {2'b10, oc};
         wire [3:0] id = {2'b11, od};
         wire [3:0] k0 = {diag_reg, JJ, 1'b0};       // Position 2i
         wire [3:0] k1 = {diag_reg, JJ, 1'b1};       // Position 2i+1
         wire [7:0] p0 = {4'h0, k0} * {4'h0, mult_w};
         wire [7:0] p1 = {4'h0, k1} * {4'h0, mult_w};
         wire [3:0] s0 = p0[3:0] + round_reg;
         wire [3:0] s1 = p1[3:0] + round_reg;
         assign ib_flat[gj*4 +: 4] = ib;
         assign ic_flat[gj*4 +: 4] = ic;
         assign id_flat[gj*4 +: 4] = id;
         hash_g_mix #(
            .WORD_W (WORD_W),
            .ROT0   (ROT0),
            .ROT1   (ROT1),
            .ROT2   (ROT2),
            .ROT3   (ROT3)
         ) u_mix (
            .a_i  (v_reg[gj*WORD_W +: WORD_W]),
            .b_i  (v_reg[ib*WORD_W +: WORD_W]),
            .c_i  (v_reg[ic*WORD_W +: WORD_W]),
            .d_i  (v_reg[id*WORD_W +: WORD_W]),
            .m0_i (msg_reg[s0*WORD_W +: WORD_W]),
            .k0_i (const_flat[s1*WORD_W +: WORD_W]),
            .m1_i (msg_reg[s1*WORD_W +: WORD_W]),
            .k1_i (const_flat[s0*WORD_W +: WORD_W]),
            .a_o  (ga_flat[gj*WORD_W +: WORD_W]),
            .b_o  (gb_flat[gj*WORD_W +: WORD_W]),
            .c_o  (gc_flat[gj*WORD_W +: WORD_W]),
            .d_o  (gd_flat[gj*WORD_W +: WORD_W])
         );
      end
   endgenerate

   // ==========================================================
   // Finalization fold, no counter term
   // ==========================================================
   integer fi;
   always @* begin
      fold_w = {8*WORD_W{1'b0}};
      for (fi = 0; fi < 8; fi = fi + 1) begin
         fold_w[fi*WORD_W +: WORD_W] =
            v_reg[fi*WORD_W +: WORD_W]
          ^ v_reg[(fi+8)*WORD_W +: WORD_W]
          ^ chain_reg[fi*WORD_W +: WORD_W]
          ^ salt_reg[(fi%4)*WORD_W +: WORD_W];
      end
   end

   // ==========================================================
   // Next state of the controller and inner state
   // ==========================================================
   integer li;
   always @* begin
      state_next = state_reg;
      round_next = round_reg;
      diag_next  = diag_reg;
      v_next     = v_reg;
      case (state_reg)
         ST_IDLE: begin
            // Wait for a block
            if (START_I) begin
               state_next = ST_LOAD;
            end
         end
         ST_LOAD: begin
            // Chain value, salt-masked and counter-masked constants
            v_next[8*WORD_W-1:0] = chain_reg;
            for (li = 0; li < 4; li = li + 1) begin
               v_next[(8+li)*WORD_W +: WORD_W] =
                  salt_reg[li*WORD_W +: WORD_W]
                ^ const_flat[li*WORD_W +: WORD_W];
            end
            v_next[12*WORD_W +: WORD_W] = count_reg[0 +: WORD_W]
               ^ const_flat[4*WORD_W +: WORD_W];
            v_next[13*WORD_W +: WORD_W] = count_reg[0 +: WORD_W]
               ^ const_flat[5*WORD_W +: WORD_W];
            v_next[14*WORD_W +: WORD_W] = count_reg[WORD_W +: WORD_W]
               ^ const_flat[6*WORD_W +: WORD_W];
            v_next[15*WORD_W +: WORD_W] = count_reg[WORD_W +: WORD_W]
               ^ const_flat[7*WORD_W +: WORD_W];
            round_next = 4'h0;
            diag_next  = 1'b0;
            state_next = ST_ROUND;
         end
         ST_ROUND: begin
            // Write the four lane results back
            for (li = 0; li < 4; li = li + 1) begin
               v_next[li*WORD_W +: WORD_W] =
                  ga_flat[li*WORD_W +: WORD_W];
               v_next[ib_flat[li*4 +: 4]*WORD_W +: WORD_W] =
                  gb_flat[li*WORD_W +: WORD_W];
               v_next[ic_flat[li*4 +: 4]*WORD_W +: WORD_W] =
                  gc_flat[li*WORD_W +: WORD_W];
               v_next[id_flat[li*4 +: 4]*WORD_W +: WORD_W] =
                  gd_flat[li*WORD_W +: WORD_W];
            end
            diag_next = ~diag_reg;
            if (diag_reg) begin
               // Round closes after its diagonal step
               if (round_reg == LAST_ROUND) begin
                  state_next = ST_FINAL;
               end else begin
                  round_next = round_reg + 4'h1;
               end
            end
         end
         ST_FINAL: begin
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Clocked update
   // ==========================================================
   always @(posedge CLK_I) begin
      if (!RST_N_I) begin
         state_reg <= ST_IDLE;
         round_reg <= 4'h0;
         diag_reg  <= 1'b0;
         v_reg     <= {16*WORD_W{1'b0}};
         msg_reg   <= {16*WORD_W{1'b0}};
         chain_reg <= {8*WORD_W{1'b0}};
         salt_reg  <= {4*WORD_W{1'b0}};
         count_reg <= {2*WORD_W{1'b0}};
         CHAIN_O   <= {8*WORD_W{1'b0}};
         DONE_O    <= 1'b0;
      end else begin
         state_reg <= state_next;
         round_reg <= round_next;
         diag_reg  <= diag_next;
         v_reg     <= v_next;
         DONE_O    <= 1'b0;
         // Capture inputs when a start is taken
         if (state_reg[0] && START_I) begin
            msg_reg   <= BLOCK_I;
            chain_reg <= CHAIN_I;
            salt_reg  <= SALT_I;
            count_reg <= COUNT_I;
         end
         // Publish result only after the last round
         if (state_reg[3]) begin
            CHAIN_O <= fold_w;
            DONE_O  <= 1'b1;
         end
      end
   end

endmodule // hash_compression_core

`default_nettype wire

// ---- testbench/hash_compression_core_assertions.sv ----
// Purpose: Port checks of the compression core
// Assumes: Bound to the core, one clock domain
// Notes  : A helper counter tracks cycles since a taken start
`timescale 1ns/10ps
`default_nettype none
module hash_compression_core_assertions #(
   parameter WORD_W = 32                    // Word width
) (
   input wire logic                CLK_I,   // Clock
   input wire logic                RST_N_I, // Sync reset, low
   input wire logic                START_I, // Start request
   input wire logic                BUSY_O,  // Busy flag
   input wire logic                DONE_O,  // Done pulse
   input wire logic [8*WORD_W-1:0] CHAIN_O  // New chain value
);
   // Edges from a taken start to the done cycle
   localparam int LAT = (WORD_W == 64) ? 35 : 31;
   logic [5:0] cnt_reg;                     // Cycles since start
   wire        take = START_I && !BUSY_O;   // Start accepted
   // ==========================================================
   // Helper counter
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I)
         cnt_reg <= 6'h00;
      else if (take)
         cnt_reg <= 6'h01;
      else if (cnt_reg != 6'h00 && cnt_reg < LAT)
         cnt_reg <= cnt_reg + 6'h01;
      else
         cnt_reg <= 6'h00;
   end
   // ==========================================================
   // Properties
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   start_busy_a: assert property (
      take |=> $rose(BUSY_O)) else $error("busy did not follow start");
   busy_window_a: assert property (
      cnt_reg != 6'h00 && cnt_reg < LAT |-> BUSY_O)
      else $error("busy dropped during rounds");
   done_delay_a: assert property (
      take |-> ##LAT DONE_O) else $error("done late or missing");
   done_timing_a: assert property (
      DONE_O |-> cnt_reg == LAT) else $error("done at wrong cycle");
   done_idle_a: assert property (
      DONE_O |-> !BUSY_O) else $error("busy high with done");
   done_pulse_a: assert property (
      DONE_O |=> !DONE_O) else $error("done longer than a cycle");
   idle_quiet_a: assert property (
      cnt_reg == 6'h00 |-> !BUSY_O && !DONE_O)
      else $error("activity without a start");
   chain_hold_a: assert property (
      !DONE_O && $past(RST_N_I) |-> $stable(CHAIN_O))
      else $error("chain output moved without done");
   reset_clear_a: assert property (
      $rose(RST_N_I) |-> !BUSY_O && !DONE_O && CHAIN_O == '0)
      else $error("outputs not cleared by reset");
   cover property (DONE_O && START_I);
   cover property (BUSY_O && START_I);
   cover property (DONE_O ##1 !BUSY_O);
endmodule // hash_compression_core_assertions
`default_nettype wire

// ---- testbench/hash_block_source.sv ----
// Purpose: Driver that presents one block, chain, salt and counter per start
// Assumes: Same clock as the core
// Notes  : Inputs are inverted once taken, so latching is exercised
`timescale 1ns/10ps
`default_nettype none
module hash_block_source #(
   parameter WORD_W = 32                       // Word width
) (
   input  wire logic                 clk_i,    // Clock
   output var  logic                 start_o,  // Start request
   output var  logic [16*WORD_W-1:0] block_o,  // Message block
   output var  logic [8*WORD_W-1:0]  chain_o,  // Chain value
   output var  logic [4*WORD_W-1:0]  salt_o,   // Salt
   output var  logic [2*WORD_W-1:0]  count_o   // Counter
);
   // ==========================================================
   // Idle levels at time zero
   initial begin
      start_o = 1'b0;
      block_o = '0;
      chain_o = '0;
      salt_o = '0;
      count_o = '0;
   end
   // One start cycle, then the data no longer holds
   task automatic launch(input logic [16*WORD_W-1:0] m,
         input logic [8*WORD_W-1:0] h, input logic [4*WORD_W-1:0] s,
         input logic [2*WORD_W-1:0] t);
      @(posedge clk_i);
      start_o <= 1'b1;
      block_o <= m;
      chain_o <= h;
      salt_o <= s;
      count_o <= t;
      @(posedge clk_i);
      start_o <= 1'b0;
      block_o <= ~m;
      chain_o <= ~h;
      salt_o <= ~s;
      count_o <= ~t;
   endtask
endmodule // hash_block_source
`default_nettype wire

// ---- testbench/hash_compression_core_bench.sv ----
// Purpose: Self-checking bench of the compression core
// Assumes: Narrow words; seed fixed for repeatable stimulus
// Notes  : A monitor queues every result for in-order comparison
`timescale 1ns/10ps
`default_nettype none
`include "hash_compression_consts.vh"
module hash_compression_core_bench;
   logic clk, rst_n, start, busy, done;       // Control
   logic [511:0] block;                       // Block
   logic [255:0] chain, chain_out;            // Chains
   logic [127:0] salt;                        // Salt
   logic [63:0]  count;                       // Counter
   logic [255:0] got[$], exp_q[$];            // Results
   integer seed = 49215;                      // Random seed
   integer failures = 0, check_count = 0;     // Tallies
   hash_compression_core u_hash_compression_core (.CLK_I(clk),
      .RST_N_I(rst_n), .START_I(start), .BLOCK_I(block),
      .CHAIN_I(chain), .SALT_I(salt), .COUNT_I(count), .BUSY_O(busy),
      .DONE_O(done), .CHAIN_O(chain_out));
   hash_block_source u_hash_block_source (.clk_i(clk), .start_o(start),
      .block_o(block), .chain_o(chain), .salt_o(salt), .count_o(count));
   // ==========================================================
   // Clock, monitor, watchdog
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (done === 1'b1)
         got.push_back(chain_out);
   end
   initial begin
      #75000;
      failures++;
      $display("MISMATCH %0t watchdog expired", $time);
      conclude();
   end
   // ==========================================================
   // Reference compression
   function automatic logic [31:0] ror(input logic [31:0] w, integer n);
      return (w >> n) | (w << (32 - n));
   endfunction
   function automatic logic [255:0] ref_hash(input logic [959:0] a);
      logic [31:0] v[16], c[16], x, y;
      logic [63:0] k;
      logic [255:0] o;
      integer r, j, q, d, p0, p1, ia, ib, ic, id;
      for (j = 0; j < 16; j++) begin
         k = `HCC_CONST_SEED ^ (`HCC_CONST_STEP * j);
         c[j] = k[31:0];
      end
      for (j = 0; j < 8; j++)
         v[j] = a[512+j*32 +: 32];
      for (j = 0; j < 4; j++) begin
         v[8+j] = a[768+j*32 +: 32] ^ c[j];
         v[12+j] = a[896+(j/2)*32 +: 32] ^ c[4+j];
      end
      for (r = 0; r < 14; r++) begin
         for (j = 0; j < 8; j++) begin
            q = j % 4;
            d = j / 4;
            ia = q;
            ib = 4 + (q + d) % 4;
            ic = 8 + (q + 2 * d) % 4;
            id = 12 + (q + 3 * d) % 4;
            p0 = (2 * j * (2 * (r % 8) + 1) + r) % 16;
            p1 = ((2 * j + 1) * (2 * (r % 8) + 1) + r) % 16;
            x = a[p0*32 +: 32] ^ c[p1];
            y = a[p1*32 +: 32] ^ c[p0];
            v[ia] = v[ia] + v[ib] + x;
            v[id] = ror(v[id] ^ v[ia], 16);
            v[ic] = v[ic] + v[id];
            v[ib] = ror(v[ib] ^ v[ic], 12);
            v[ia] = v[ia] + v[ib] + y;
            v[id] = ror(v[id] ^ v[ia], 8);
            v[ic] = v[ic] + v[id];
            v[ib] = ror(v[ib] ^ v[ic], 7);
         end
      end
      for (j = 0; j < 8; j++)
         o[j*32 +: 32] = v[j] ^ v[j+8] ^ a[512+j*32 +: 32]
            ^ a[768+(j%4)*32 +: 32];
      return o;
   endfunction
   // ==========================================================
   // Stimulus and comparison tasks
   task automatic issue(input bit keep, input integer mode);
      logic [959:0] a;
      integer i;
      for (i = 0; i < 30; i++)
         a[i*32 +: 32] = (mode == 1) ? 32'h0000_0000 :
            (mode == 2) ? 32'hFFFF_FFFF : $random(seed);
      if (keep)
         exp_q.push_back(ref_hash(a));
      u_hash_block_source.launch(a[511:0], a[767:512], a[895:768],
         a[959:896]);
   endtask
   task automatic settle(input integer extra);
      integer n;
      for (n = 0; n < 80 && got.size() < exp_q.size(); n++)
         @(posedge clk);
      repeat (extra) @(posedge clk);
   endtask
   task automatic verify(input string what);
      check_count++;
      if (got.size() != exp_q.size()) begin
         failures++;
         $display("MISMATCH %0t %s result count", $time, what);
      end
      while (got.size() > 0 && exp_q.size() > 0) begin
         check_count++;
         if (got.pop_front() !== exp_q.pop_front()) begin
            failures++;
            $display("MISMATCH %0t %s chain value", $time, what);
         end
      end
      got.delete();
      exp_q.delete();
      $display("test %s done", what);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check_count++;
      if (busy !== 1'b0 || done !== 1'b0 || chain_out !== '0) begin
         failures++;
         $display("MISMATCH %0t reset values", $time);
      end
      $display("test reset values done");
      issue(1, 1);
      settle(3);
      issue(1, 2);
      settle(3);
      verify("corner words");
      repeat (6) begin
         issue(1, 0);
         settle(3);
      end
      verify("random blocks");
      issue(1, 0);
      repeat (29) @(posedge clk);
      issue(1, 0);
      settle(3);
      verify("back to back");
      issue(1, 0);
      repeat (5) @(posedge clk);
      issue(0, 0);
      settle(40);
      verify("start while busy");
      issue(0, 0);
      repeat (10) @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      issue(1, 0);
      settle(3);
      verify("reset mid run");
      conclude();
   end
endmodule // hash_compression_core_bench
bind hash_compression_core hash_compression_core_assertions
   #(.WORD_W(WORD_W)) u_hash_compression_core_assertions (.CLK_I(CLK_I),
   .RST_N_I(RST_N_I), .START_I(START_I), .BUSY_O(BUSY_O),
   .DONE_O(DONE_O), .CHAIN_O(CHAIN_O));
`default_nettype wire
